/* File: raoch_pkg.sv */
package raoch_pkg;
    // command engine states
    typedef enum logic [2:0] {
        RAOCH_IDLE, RAOCH_DECODE, RAOCH_INS_REQ, RAOCH_INS_WAIT,
        RAOCH_RESPOND, RAOCH_IRQ
    } raoch_state_t;
endpackage

/* File: raoch_regs.svh */
// Function
// R1 - statistics dump clears counters after copying
// R2 - option modify: code 01, results 00/01/04
// R3 - write result byte, then interrupt host
// R4 - insert command 03 with option, addresses
// R5 - addresses byte-swapped; zero selects default
// R6 - protocol select: 0 fallback, 1 token, 2 immediate
// R7 - offset 33 inhibits congestion frame
// R8 - bit0 contention; claim token always started
// R9 - host writes reserved option bits zero
// R10 - bit3 forwards changed attention frames
// R11 - bit4 forwards unsupported class frames
// R12 - bits 5/6 mask soft/hard interrupts
// R13 - bit7 loops transmit back internally
// R14 - bit11 selects half duplex
// R15 - bit12 inhibits early release at 16M
// R16 - bit13 no monitor; fail when alone
// R17 - bit15 forwards first and changed beacons
// R18 - insert response layout, error at 7
// R19 - offset 14 points at version text
// R20 - offset 16 nonzero when immediate access
// R21 - host loops back local LLC frames
// R22 - open error: phase nibble, condition nibble
`ifndef RAOCH_REGS_SVH
`define RAOCH_REGS_SVH
`define RAOCH_BLK_BYTES   64
`define RAOCH_REG_CTRL    7'h40
`define RAOCH_CMD_MODIFY  8'h01
`define RAOCH_CMD_INSERT  8'h03
`define RAOCH_CMD_STATS   8'h13
`define RAOCH_RC_OK       8'h00
`define RAOCH_RC_BADCMD   8'h01
`define RAOCH_RC_CLOSED   8'h04
`define RAOCH_RC_OPENERR  8'h07
`define RAOCH_OFF_CMD     0
`define RAOCH_OFF_RC      2
`define RAOCH_OFF_MODOPT  4
`define RAOCH_OFF_ERR     7
`define RAOCH_OFF_OPT     8
`define RAOCH_OFF_STA     10
`define RAOCH_OFF_GRP     16
`define RAOCH_OFF_FUN     20
`define RAOCH_OFF_PROT    32
`define RAOCH_OFF_CONG    33
`define RAOCH_OFF_RSTAT   8
`define RAOCH_OFF_RREQ    10
`define RAOCH_OFF_RADP    12
`define RAOCH_OFF_VER     14
`define RAOCH_OFF_DTR     16
`define RAOCH_OFF_CNT     4
`define RAOCH_PROT_AUTO   8'h00
`define RAOCH_PROT_TOKEN  8'h01
`define RAOCH_PROT_IMMED  8'h02
`define RAOCH_PH_INSERT   4'h2
`define RAOCH_CD_NOMON    4'hD
`define RAOCH_BIT_CONTEND 0
`define RAOCH_BIT_ATTN    3
`define RAOCH_BIT_UNSUP   4
`define RAOCH_BIT_SOFT    5
`define RAOCH_BIT_HARD    6
`define RAOCH_BIT_LOOP    7
`define RAOCH_BIT_HALF    11
`define RAOCH_BIT_NOETR   12
`define RAOCH_BIT_BOOT    13
`define RAOCH_BIT_BEACON  15
`endif

/* File: raoch_ring_model.sv */
`timescale 1ns/10ps
// ring side: answers each insertion attempt after a short or long wait
module raoch_ring_model (
    input  wire logic       clock,
    input  wire logic       resetn,
    input  wire logic       ring_insert_req,
    input  wire logic       transmit_immediate_access,
    input  wire logic       slow,       // long insertion time
    input  wire logic       fail_immed, // immediate access attempts fail
    input  wire logic       alone,      // no other station on the ring
    output logic            insert_done,
    output logic            insert_ok,
    output logic      [7:0] insert_err,
    output logic            other_station_seen
);
    logic [4:0] cnt;  // cycles left before the answer
    logic       imm_try; // access kind of the pending attempt
    logic       ok_v; // verdict of the pending attempt
    // only an immediate access attempt can be made to fail
    assign ok_v = !(fail_immed && imm_try);
    // qualifiers hold only beside done, otherwise shown inverted
    assign insert_ok = insert_done ? ok_v : !ok_v;
    // physical insertion phase, ring beaconing condition
    assign insert_err = insert_done ? (ok_v ? 8'h00 : 8'h27) : (ok_v ? 8'hFF : 8'hD8);
    assign other_station_seen = insert_done ? !alone : alone;
    // attempt timer
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cnt <= 5'h00;
            imm_try <= 1'b0;
            insert_done <= 1'b0;
        end else begin
            insert_done <= (cnt == 5'h01);
            if (cnt != 5'h00) begin
                cnt <= cnt - 5'h01;
            end else if (ring_insert_req) begin
                cnt <= slow ? 5'h14 : 5'h02;
                imm_try <= transmit_immediate_access;
            end
        end
    end
endmodule // raoch_ring_model

/* File: raoch_top.sv */
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`include "raoch_regs.svh"
module raoch_top import raoch_pkg::*; #(
    parameter logic [47:0] NODE_ADDR = 48'h0000_0000_0001, // stored node address
    parameter logic [15:0] STAT_PTR  = 16'h0100,  // status block pointer
    parameter logic [15:0] REQ_PTR   = 16'h0200,  // request block pointer
    parameter logic [15:0] ADP_PTR   = 16'h0300,  // adapter request pointer
    parameter logic [15:0] VER_PTR   = 16'h0400   // version text pointer
) (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic [6:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [7:0]  rdata,
    input  wire logic        rx_frame_evt,
    input  wire logic        tx_frame_evt,
    input  wire logic        rx_overrun,
    input  wire logic        soft_fault_evt,
    input  wire logic        hard_fault_evt,
    input  wire logic        monitor_needed,
    input  wire logic        ring_16mbps,
    input  wire logic        insert_done,
    input  wire logic        insert_ok,
    input  wire logic [7:0]  insert_err,
    input  wire logic        other_station_seen,
    output logic             host_irq,
    output logic             ring_insert_req,
    output logic             transmit_immediate_access,
    output logic             adapter_open,
    output logic      [47:0] station_address,
    output logic      [31:0] group_address,
    output logic             group_enable,
    output logic      [31:0] funct_address,
    output logic             funct_enable,
    output logic             contend_enable,
    output logic             claim_token_start,
    output logic             forward_attention_frames,
    output logic             forward_unsupported_class_frames,
    output logic             forward_beacon_frames,
    output logic             ring_status_irq,
    output logic             internal_loop_enable,
    output logic             half_duplex,
    output logic             early_release_active,
    output logic             boot_station_insert,
    output logic             congestion_frame_req
);
    raoch_state_t state;           // engine state
    logic [7:0]  blk [`RAOCH_BLK_BYTES]; // request block bytes
    logic [15:0] opt;              // option word in force
    logic        inhibit;          // congestion report inhibit
    logic [7:0]  prot;             // access protocol select
    logic        fallback;         // second attempt underway
    logic [7:0]  rc;               // result for response
    logic [7:0]  err;              // open error byte
    logic [15:0] rx_cnt;           // received frame counter
    logic [15:0] tx_cnt;           // transmitted frame counter
    logic        stats_clr;        // counter clear pulse
    logic        start;            // doorbell write
    logic [47:0] sta_in;           // station address, ieee order
    logic [31:0] grp_in;           // group address, ieee order
    logic [31:0] fun_in;           // functional address, ieee order
    logic [15:0] opt_new;          // modify option word

    assign start = wr && (addr == `RAOCH_REG_CTRL) && (state == RAOCH_IDLE);
    // undo the per-word swap of host addresses
    assign sta_in = {blk[11], blk[10], blk[13], blk[12], blk[15], blk[14]}; // [R5]
    assign grp_in = {blk[17], blk[16], blk[19], blk[18]}; // [R5]
    assign fun_in = {blk[21], blk[20], blk[23], blk[22]}; // [R5]
    assign opt_new = {blk[`RAOCH_OFF_MODOPT + 1], blk[`RAOCH_OFF_MODOPT]};

    // command sequencing
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= RAOCH_IDLE;
            rc <= 8'h00;
            err <= 8'h00;
            fallback <= 1'b0;
            stats_clr <= 1'b0;
        end else begin
            stats_clr <= 1'b0;
            case (state)
                RAOCH_IDLE: begin
                    if (start) begin
                        state <= RAOCH_DECODE;
                    end
                end
                RAOCH_DECODE: begin
                    err <= 8'h00;
                    fallback <= 1'b0;
                    state <= RAOCH_RESPOND;
                    if (blk[`RAOCH_OFF_CMD] == `RAOCH_CMD_MODIFY) begin // [R2]
                        rc <= adapter_open ? `RAOCH_RC_OK : `RAOCH_RC_CLOSED;
                    end else if (blk[`RAOCH_OFF_CMD] == `RAOCH_CMD_INSERT) begin // [R4]
                        state <= RAOCH_INS_REQ;
                    end else if (blk[`RAOCH_OFF_CMD] == `RAOCH_CMD_STATS) begin
                        rc <= adapter_open ? `RAOCH_RC_OK : `RAOCH_RC_CLOSED;
                        stats_clr <= adapter_open; // [R1]
                    end else begin
                        rc <= `RAOCH_RC_BADCMD; // [R2]
                    end
                end
                RAOCH_INS_REQ: begin
                    state <= RAOCH_INS_WAIT;
                end
                RAOCH_INS_WAIT: begin
                    if (insert_done) begin
                        state <= RAOCH_RESPOND;
                        if (opt[`RAOCH_BIT_BOOT] && !other_station_seen) begin
                            // alone on the ring: refuse to become monitor
                            rc <= `RAOCH_RC_OPENERR; // [R16]
                            err <= {`RAOCH_PH_INSERT, `RAOCH_CD_NOMON}; // [R22]
                        end else if (insert_ok) begin
                            rc <= `RAOCH_RC_OK;
                        end else if (prot == `RAOCH_PROT_AUTO && !fallback) begin
                            // immediate access failed, retry with token
                            fallback <= 1'b1; // [R6]
                            state <= RAOCH_INS_REQ;
                        end else begin
                            rc <= `RAOCH_RC_OPENERR;
                            err <= insert_err; // [R22]
                        end
                    end
                end
                RAOCH_RESPOND: begin
                    state <= RAOCH_IRQ; // [R3]
                end
                default: begin
                    state <= RAOCH_IDLE;
                end
            endcase
        end
    end

    // insertion request pulse and access mode
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ring_insert_req <= 1'b0;
            transmit_immediate_access <= 1'b0;
        end else begin
            ring_insert_req <= (state == RAOCH_INS_REQ);
            if (state == RAOCH_INS_REQ) begin
                // auto tries immediate first, then token
                transmit_immediate_access <= (prot == `RAOCH_PROT_IMMED) ||
                    ((prot == `RAOCH_PROT_AUTO) && !fallback); // [R6]
            end
        end
    end

    // open state, options and addresses
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            adapter_open <= 1'b0;
            opt <= 16'h0000;
            prot <= `RAOCH_PROT_AUTO;
            inhibit <= 1'b0;
            station_address <= 48'h0;
            group_address <= 32'h0;
            group_enable <= 1'b0;
            funct_address <= 32'h0;
            funct_enable <= 1'b0;
        end else if (state == RAOCH_DECODE) begin
            if (blk[`RAOCH_OFF_CMD] == `RAOCH_CMD_MODIFY && adapter_open) begin
                opt <= opt_new; // [R2]
            end else if (blk[`RAOCH_OFF_CMD] == `RAOCH_CMD_INSERT) begin
                opt <= {blk[`RAOCH_OFF_OPT + 1], blk[`RAOCH_OFF_OPT]}; // [R4]
                prot <= blk[`RAOCH_OFF_PROT]; // [R6]
                inhibit <= blk[`RAOCH_OFF_CONG][0]; // [R7]
                station_address <= (sta_in == 48'h0) ? NODE_ADDR : sta_in; // [R5]
                group_address <= grp_in;
                group_enable <= (grp_in != 32'h0); // [R5]
                funct_address <= fun_in;
                funct_enable <= (fun_in != 32'h0); // [R5]
            end
        end else if (state == RAOCH_INS_WAIT && insert_done) begin
            adapter_open <= insert_ok && !(opt[`RAOCH_BIT_BOOT] && !other_station_seen);
        end
    end

    // request block: host writes, engine writes responses
    always_ff @(posedge clock) begin
        if (wr && addr < 7'(`RAOCH_BLK_BYTES)) begin
            blk[addr[5:0]] <= wdata;
        end
        if (state == RAOCH_RESPOND) begin
            blk[`RAOCH_OFF_RC] <= rc; // [R3]
            if (blk[`RAOCH_OFF_CMD] == `RAOCH_CMD_INSERT) begin
                blk[`RAOCH_OFF_ERR] <= err; // [R18]
                blk[`RAOCH_OFF_RSTAT] <= STAT_PTR[7:0];
                blk[`RAOCH_OFF_RSTAT + 1] <= STAT_PTR[15:8];
                blk[`RAOCH_OFF_RREQ] <= REQ_PTR[7:0];
                blk[`RAOCH_OFF_RREQ + 1] <= REQ_PTR[15:8];
                blk[`RAOCH_OFF_RADP] <= ADP_PTR[7:0];
                blk[`RAOCH_OFF_RADP + 1] <= ADP_PTR[15:8];
                blk[`RAOCH_OFF_VER] <= VER_PTR[7:0]; // [R19]
                blk[`RAOCH_OFF_VER + 1] <= VER_PTR[15:8];
                blk[`RAOCH_OFF_DTR] <= {7'h00, transmit_immediate_access}; // [R20]
            end
        end
        if (stats_clr) begin
            // counter snapshot taken before the clear
            blk[`RAOCH_OFF_CNT] <= rx_cnt[7:0]; // [R1]
            blk[`RAOCH_OFF_CNT + 1] <= rx_cnt[15:8];
            blk[`RAOCH_OFF_CNT + 2] <= tx_cnt[7:0];
            blk[`RAOCH_OFF_CNT + 3] <= tx_cnt[15:8];
        end
    end

    // statistics counters, cleared on dump; new event survives clear
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rx_cnt <= 16'h0000;
            tx_cnt <= 16'h0000;
        end else begin
            rx_cnt <= (stats_clr ? 16'h0000 : rx_cnt) + {15'h0000, rx_frame_evt}; // [R1]
            tx_cnt <= (stats_clr ? 16'h0000 : tx_cnt) + {15'h0000, tx_frame_evt}; // [R1]
        end
    end

    // completion interrupt after the result byte
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            host_irq <= 1'b0;
        end else begin
            host_irq <= (state == RAOCH_IRQ); // [R3]
        end
    end

    // option-driven ring controls
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            contend_enable <= 1'b0;
            claim_token_start <= 1'b0;
            forward_attention_frames <= 1'b0;
            forward_unsupported_class_frames <= 1'b0;
            forward_beacon_frames <= 1'b0;
            ring_status_irq <= 1'b0;
            internal_loop_enable <= 1'b0;
            half_duplex <= 1'b0;
            early_release_active <= 1'b0;
            boot_station_insert <= 1'b0;
            congestion_frame_req <= 1'b0;
        end else begin
            contend_enable <= opt[`RAOCH_BIT_CONTEND]; // [R8]
            claim_token_start <= monitor_needed; // [R8]
            forward_attention_frames <= opt[`RAOCH_BIT_ATTN]; // [R10]
            forward_unsupported_class_frames <= opt[`RAOCH_BIT_UNSUP]; // [R11]
            forward_beacon_frames <= opt[`RAOCH_BIT_BEACON]; // [R17]
            ring_status_irq <= (soft_fault_evt && !opt[`RAOCH_BIT_SOFT]) ||
                               (hard_fault_evt && !opt[`RAOCH_BIT_HARD]); // [R12]
            internal_loop_enable <= opt[`RAOCH_BIT_LOOP]; // [R13]
            half_duplex <= opt[`RAOCH_BIT_HALF]; // [R14]
            early_release_active <= ring_16mbps && !opt[`RAOCH_BIT_NOETR]; // [R15]
            boot_station_insert <= opt[`RAOCH_BIT_BOOT]; // [R16]
            congestion_frame_req <= rx_overrun && !inhibit; // [R7]
        end
    end

    // register read port, one cycle latency
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rdata <= 8'h00;
        end else if (!rd) begin
            rdata <= 8'h00;
        end else if (addr < 7'(`RAOCH_BLK_BYTES)) begin
            rdata <= blk[addr[5:0]];
        end else if (addr == `RAOCH_REG_CTRL) begin
            rdata <= {5'h00, state != RAOCH_IDLE, adapter_open, transmit_immediate_access};
        end else begin
            rdata <= 8'h00; // unmapped
        end
    end

    // checks
    result_before_irq_a: assert property (@(posedge clock) disable iff (!resetn) // [R3]
        host_irq |-> $past(state, 2) == RAOCH_RESPOND) else $error("irq without result");
    modify_closed_a: assert property (@(posedge clock) disable iff (!resetn) // [R2]
        state == RAOCH_DECODE && blk[0] == `RAOCH_CMD_MODIFY && !adapter_open
        |=> rc == `RAOCH_RC_CLOSED) else $error("modify closed code");
    stats_clear_a: assert property (@(posedge clock) disable iff (!resetn) // [R1]
        stats_clr && !rx_frame_evt |=> rx_cnt == 16'h0000) else $error("counter kept");
    soft_mask_a: assert property (@(posedge clock) disable iff (!resetn) // [R12]
        soft_fault_evt && !hard_fault_evt && opt[5] |=> !ring_status_irq)
        else $error("soft irq leaked");
    loop_follow_a: assert property (@(posedge clock) disable iff (!resetn) // [R13]
        ##1 internal_loop_enable == $past(opt[7])) else $error("loop bit lag");
    token_only_a: assert property (@(posedge clock) disable iff (!resetn) // [R6]
        state == RAOCH_INS_REQ && prot == `RAOCH_PROT_TOKEN
        |=> !transmit_immediate_access) else $error("token only broken");
    congest_gate_a: assert property (@(posedge clock) disable iff (!resetn) // [R7]
        rx_overrun && !inhibit |=> congestion_frame_req) else $error("no congestion frame");
    lone_boot_a: assert property (@(posedge clock) disable iff (!resetn) // [R16]
        state == RAOCH_INS_WAIT && insert_done && opt[13] && !other_station_seen
        |=> !adapter_open && err == 8'h2D) else $error("boot insert not failed");
    etr_gate_a: assert property (@(posedge clock) disable iff (!resetn) // [R15]
        !ring_16mbps |=> !early_release_active) else $error("early release at 4M");
endmodule // raoch_top

/* File: ring_adapter_open_command_handler_tb.sv */
`timescale 1ns/10ps
`include "raoch_regs.svh"
module ring_adapter_open_command_handler_tb;
    localparam logic [15:0] SP = 16'h1357, RP = 16'h2468, AP = 16'h369C, VP = 16'h4A5B;
    localparam logic [47:0] NA = 48'hA1B2C3D4E5F6; // arbitrary stored node address
    // host-order address bytes at offsets 10..23
    localparam logic [7:0] AB [0:13] = '{8'h22, 8'h11, 8'h44, 8'h33, 8'h66, 8'h55,
        8'hBB, 8'hAA, 8'hDD, 8'hCC, 8'h00, 8'h00, 8'h00, 8'h00};
    logic clock = 0, resetn = 0, wr = 0, rd = 0, rx_frame_evt = 0, tx_frame_evt = 0;
    logic rx_overrun = 0, soft_fault_evt = 0, hard_fault_evt = 0, monitor_needed = 0;
    logic ring_16mbps = 0, slow = 0, fail_immed = 0, alone = 0;
    logic [6:0] addr = 0;
    logic [7:0] wdata = 0, rdata, insert_err;
    logic host_irq, ring_insert_req, transmit_immediate_access, adapter_open, group_enable;
    logic funct_enable, contend_enable, claim_token_start, forward_attention_frames;
    logic forward_unsupported_class_frames, forward_beacon_frames, ring_status_irq;
    logic internal_loop_enable, half_duplex, early_release_active, boot_station_insert;
    logic congestion_frame_req, insert_done, insert_ok, other_station_seen;
    logic [47:0] station_address;
    logic [31:0] group_address, funct_address;
    int error_cnt = 0, tests_run = 0, n_req = 0, n_rsi = 0, n_cong = 0, n_clm = 0;
    raoch_top #(.NODE_ADDR(NA), .STAT_PTR(SP), .REQ_PTR(RP), .ADP_PTR(AP), .VER_PTR(VP)) dut (
        .clock, .resetn, .addr, .wdata, .wr, .rd, .rdata, .rx_frame_evt, .tx_frame_evt,
        .rx_overrun, .soft_fault_evt, .hard_fault_evt, .monitor_needed, .ring_16mbps,
        .insert_done, .insert_ok, .insert_err, .other_station_seen, .host_irq,
        .ring_insert_req, .transmit_immediate_access, .adapter_open, .station_address,
        .group_address, .group_enable, .funct_address, .funct_enable, .contend_enable,
        .claim_token_start, .forward_attention_frames, .forward_unsupported_class_frames,
        .forward_beacon_frames, .ring_status_irq, .internal_loop_enable, .half_duplex,
        .early_release_active, .boot_station_insert, .congestion_frame_req);
    raoch_ring_model ring (.clock, .resetn, .ring_insert_req, .transmit_immediate_access,
        .slow, .fail_immed, .alone, .insert_done, .insert_ok, .insert_err, .other_station_seen);
    // 20 MHz clock
    always #25 clock = ~clock;
    // pulse counters on the design's event outputs
    always @(posedge clock) begin
        n_req += ring_insert_req;
        n_rsi += ring_status_irq;
        n_cong += congestion_frame_req;
        n_clm += claim_token_start;
    end
    task automatic chk_v(input logic [63:0] g, input logic [63:0] e);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk_f(input logic g, input logic e);
        chk_v({63'h0, g}, {63'h0, e});
    endtask
    task automatic wrb(input logic [6:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    // read data stand in the cycle after the strobe
    task automatic rdn(input int off, input int n, output logic [63:0] v);
        v = 64'h0;
        for (int i = 0; i < n; i++) begin
            @(posedge clock);
            addr <= 7'(off + i);
            rd <= 1'b1;
            @(posedge clock);
            rd <= 1'b0;
            #1 v[8*i+:8] = rdata;
        end
    endtask
    task automatic cmd(input logic [7:0] code, output logic [63:0] rc);
        int i;
        i = 0;
        wrb(7'h00, code);
        wrb(`RAOCH_REG_CTRL, 8'h00);
        do begin
            @(posedge clock);
            #1 i++;
        end while (host_irq !== 1'b1 && i < 200);
        chk_f(i < 200, 1'b1);
        @(posedge clock);
        #1 chk_f(host_irq, 1'b0);
        rdn(`RAOCH_OFF_RC, 1, rc);
    endtask
    task automatic pulse(input int k);
        @(posedge clock);
        case (k)
            0: rx_frame_evt <= 1'b1;
            1: tx_frame_evt <= 1'b1;
            2: rx_overrun <= 1'b1;
            3: soft_fault_evt <= 1'b1;
            4: hard_fault_evt <= 1'b1;
            default: monitor_needed <= 1'b1;
        endcase
        @(posedge clock);
        {rx_frame_evt, tx_frame_evt, rx_overrun} <= 3'b000;
        {soft_fault_evt, hard_fault_evt, monitor_needed} <= 3'b000;
        repeat (3) @(posedge clock);
    endtask
    // fills the insertion request block and runs it
    task automatic ins(input logic [15:0] opt, input logic [7:0] prot, input logic [7:0] cong,
                       input logic zero_addr, output logic [63:0] rc);
        wrb(7'd8, opt[7:0]);
        wrb(7'd9, opt[15:8]);
        for (int i = 0; i < 14; i++) wrb(7'(10 + i), zero_addr ? 8'h00 : AB[i]);
        wrb(7'd32, prot);
        wrb(7'd33, cong);
        cmd(`RAOCH_CMD_INSERT, rc);
    endtask
    task automatic t_closed;
        logic [63:0] v;
        rdn(`RAOCH_REG_CTRL, 1, v);
        chk_v(v, 64'h0);
        wrb(7'd4, 8'h01);
        wrb(7'd5, 8'h00);
        cmd(`RAOCH_CMD_MODIFY, v);
        chk_v(v, `RAOCH_RC_CLOSED);
        chk_f(contend_enable, 1'b0);
        chk_f(early_release_active, 1'b0);
        cmd(`RAOCH_CMD_STATS, v);
        chk_v(v, `RAOCH_RC_CLOSED);
        cmd(8'h55, v);
        chk_v(v, `RAOCH_RC_BADCMD);
        wrb(7'h41, 8'hA5);
        rdn(7'h41, 1, v);
        chk_v(v, 64'h0);
        $display("closed adapter test done");
    endtask
    task automatic t_boot;
        logic [63:0] v;
        alone = 1'b1;
        ins(16'h2000, `RAOCH_PROT_TOKEN, 8'h00, 1'b0, v);
        chk_v(v, `RAOCH_RC_OPENERR);
        rdn(`RAOCH_OFF_ERR, 1, v);
        chk_v(v, 64'h2D);
        chk_f(adapter_open, 1'b0);
        alone = 1'b0;
        $display("lone boot station test done");
    endtask
    task automatic t_insert;
        logic [63:0] v;
        int r;
        r = n_req;
        @(posedge clock) ring_16mbps <= 1'b1;
        ins(16'h80F9, `RAOCH_PROT_TOKEN, 8'h01, 1'b0, v);
        chk_v(v, `RAOCH_RC_OK);
        chk_v(n_req - r, 1);
        chk_f(adapter_open, 1'b1);
        chk_v(station_address, 48'h112233445566);
        chk_v({group_enable, group_address}, 33'h1AABBCCDD);
        chk_v({funct_enable, funct_address}, 33'h0);
        rdn(`RAOCH_OFF_RSTAT, 8, v);
        chk_v(v, {VP, AP, RP, SP});
        rdn(`RAOCH_OFF_DTR, 1, v);
        chk_v(v, 64'h0);
        chk_f(transmit_immediate_access, 1'b0);
        chk_f(contend_enable, 1'b1);
        chk_f(forward_attention_frames, 1'b1);
        chk_f(forward_unsupported_class_frames, 1'b1);
        chk_f(forward_beacon_frames, 1'b1);
        chk_v({internal_loop_enable, half_duplex, early_release_active}, 3'b101);
        pulse(3);
        pulse(4);
        pulse(2);
        chk_v({n_rsi, n_cong}, 64'h0);
        $display("insertion test done");
    endtask
    task automatic t_modify;
        logic [63:0] v;
        wrb(7'd4, 8'h00);
        wrb(7'd5, 8'h38);
        cmd(`RAOCH_CMD_MODIFY, v);
        chk_v(v, `RAOCH_RC_OK);
        chk_v({half_duplex, early_release_active, boot_station_insert}, 3'b101);
        chk_v({contend_enable, forward_attention_frames, forward_unsupported_class_frames,
               forward_beacon_frames, internal_loop_enable}, 5'b0);
        pulse(5);
        chk_v(n_clm, 1);
        pulse(3);
        pulse(4);
        chk_v(n_rsi, 2);
        $display("option modify test done");
    endtask
    task automatic t_stats;
        logic [63:0] v;
        cmd(`RAOCH_CMD_STATS, v);
        repeat (3) pulse(0);
        repeat (2) pulse(1);
        cmd(`RAOCH_CMD_STATS, v);
        chk_v(v, `RAOCH_RC_OK);
        rdn(`RAOCH_OFF_CNT, 4, v);
        chk_v(v, 64'h0002_0003);
        cmd(`RAOCH_CMD_STATS, v);
        rdn(`RAOCH_OFF_CNT, 4, v);
        chk_v(v, 64'h0);
        $display("statistics test done");
    endtask
    task automatic t_fallback;
        logic [63:0] v;
        int r;
        r = n_req;
        {fail_immed, slow} = 2'b11;
        ins(16'h0000, `RAOCH_PROT_AUTO, 8'h00, 1'b1, v);
        chk_v(v, `RAOCH_RC_OK);
        chk_v(n_req - r, 2);
        chk_v({station_address, group_enable, funct_enable}, {NA, 2'b00});
        rdn(`RAOCH_OFF_DTR, 1, v);
        chk_v(v, 64'h0);
        // immediate only: a failed attempt is not retried
        {fail_immed, slow} = 2'b10;
        r = n_req;
        ins(16'h0000, `RAOCH_PROT_IMMED, 8'h00, 1'b1, v);
        chk_v(v, `RAOCH_RC_OPENERR);
        chk_v(n_req - r, 1);
        rdn(`RAOCH_OFF_ERR, 1, v);
        chk_v(v, 64'h27);
        {fail_immed, slow} = 2'b00;
        ins(16'h0000, `RAOCH_PROT_IMMED, 8'h00, 1'b1, v);
        chk_v(v, `RAOCH_RC_OK);
        rdn(`RAOCH_OFF_DTR, 1, v);
        chk_f(v != 64'h0, 1'b1);
        rdn(`RAOCH_REG_CTRL, 1, v);
        chk_v(v[1:0], 2'b11);
        chk_f(early_release_active, 1'b1);
        pulse(2);
        chk_v(n_cong, 1);
        $display("access protocol test done");
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // hang guard at 20000 cycles, well beyond the few hundred cycles the tests need
    initial begin
        #(50 * 20000);
        error_cnt++;
        end_of_test;
    end
    initial begin
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        t_closed;
        t_boot;
        t_insert;
        t_modify;
        t_stats;
        t_fallback;
        end_of_test;
    end
endmodule // ring_adapter_open_command_handler_tb
